/* sec_ctrl.sv */
// Purpose: Reset requests, clear-active, sleep hints, event register and lock-up
// Assumes: Hint and fault inputs are one-cycle pulses, mutually exclusive
// Notes:   Lower priority number means more urgent
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module sec_ctrl
(
  // Clock and power-on reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // Register port
  input  wire sec_pkg::sec_bus_t bus_i,
  output logic [31:0]           rdata_o,
  // Hints and exception traffic
  input  wire logic             wait_for_event_hint_i,
  input  wire logic             wait_for_interrupt_hint_i,
  input  wire logic             send_event_hint_i,
  input  wire logic             exc_return_i,
  input  wire logic             ret_last_active_i,
  input  wire logic             exc_enter_i,
  input  wire logic [8:0]       exc_num_i,
  input  wire logic             pend_new_i,
  input  wire logic             async_i,
  input  wire logic [7:0]       async_prio_i,
  input  wire logic [7:0]       act_prio_i,
  input  wire logic             dbg_evt_i,
  input  wire logic             event_in_i,
  input  wire sec_pkg::sec_flt_t flt_i,
  // Power and reset control
  output logic                  sleeping_o,
  output logic                  deep_sleep_o,
  output logic                  resume_o,
  output logic                  ret_held_o,
  output logic                  chain_o,
  output logic                  event_out_o,
  output logic                  sys_reset_req_o,
  output logic                  local_rst_o,
  output logic                  clr_active_o,
  output logic                  dbg_halt_o,
  // Fault results
  output logic                  lockup_o,
  output logic [1:0]            lockup_prio_o,
  output logic [31:0]           lockup_addr_o,
  output logic                  hf_tailchain_o
);
  import sec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic       loc_q;
  logic       pm_q;
  logic       fm_q;
  logic [7:0] base_q;
  logic       slp_ret_q;
  logic       deep_q;
  logic       pend_ev_q;
  logic       dbg_en_q;
  logic       halt_q;
  logic       req_q;
  logic [7:0] cnt_q;
  logic [8:0] exc_num_q;
  logic       ev_q;
  logic       lock_q;
  logic [1:0] lprio_q;
  logic [31:0] laddr_q;
  sec_state_t st_q;
  sec_state_t st_d;

  wire wr_rst  = bus_i.we && (bus_i.addr == OFF_RST);
  wire wr_scr  = bus_i.we && (bus_i.addr == OFF_SCR);
  wire wr_mask = bus_i.we && (bus_i.addr == OFF_MASK);
  wire wr_dbg  = bus_i.we && (bus_i.addr == OFF_DBG);
  wire clr_act = wr_rst && bus_i.wdata[B_CLR_ACT];
  wire sys_wr  = wr_rst && bus_i.wdata[B_SYS_REQ];
  // Both bits together is undefined use; the system request is given priority
  wire vec_wr  = wr_rst && bus_i.wdata[B_LOC_RST] && !bus_i.wdata[B_SYS_REQ];
  wire req_due = req_q && (cnt_q == 8'h00);

  wire [1:0] st_code = st_q;
  wire [31:0] stat_w = {15'h0000, exc_num_q, req_q, lprio_q, lock_q, 2'h0, st_code};
  wire [31:0] scr_w  = {27'h0000000, pend_ev_q, 1'h0, deep_q, slp_ret_q, 1'h0};
  wire [31:0] mask_w = {16'h0000, base_q, 6'h00, fm_q, pm_q};
  wire [31:0] dbg_w  = {30'h00000000, halt_q, dbg_en_q};
  wire [31:0] rd_w =
    (bus_i.addr == OFF_SCR)  ? scr_w  :
    (bus_i.addr == OFF_MASK) ? mask_w :
    (bus_i.addr == OFF_STAT) ? stat_w :
    (bus_i.addr == OFF_LKAD) ? laddr_q :
    (bus_i.addr == OFF_DBG)  ? dbg_w  : RD_ZERO;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= RD_ZERO;
    else
      rdata_o <= bus_i.re ? rd_w : RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset requests

  // Request stays up until the delayed local reset fires
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      req_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (sys_wr && !req_q)
    begin
      req_q <= 1'b1;
      cnt_q <= SRST_CNT_INIT;
    end
    else if (req_due)
      req_q <= 1'b0;
    else if (req_q)
      cnt_q <= cnt_q - 8'h01;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      loc_q <= 1'b0;
    else
      loc_q <= vec_wr || req_due;
  end

  assign sys_reset_req_o = req_q;
  assign local_rst_o     = loc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Local reset clears everything but the debug enable
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pm_q      <= 1'b0;
      fm_q      <= 1'b0;
      base_q    <= 8'h00;
      slp_ret_q <= 1'b0;
      deep_q    <= 1'b0;
      pend_ev_q <= 1'b0;
      halt_q    <= 1'b0;
    end
    else if (loc_q)
    begin
      pm_q      <= 1'b0;
      fm_q      <= 1'b0;
      base_q    <= 8'h00;
      slp_ret_q <= 1'b0;
      deep_q    <= 1'b0;
      pend_ev_q <= 1'b0;
      halt_q    <= 1'b0;
    end
    else
    begin
      if (wr_mask)
      begin
        pm_q   <= bus_i.wdata[B_PRI_MSK];
        fm_q   <= bus_i.wdata[B_FLT_MSK];
        base_q <= bus_i.wdata[B_BASE_LO +: 8];
      end
      if (wr_scr)
      begin
        slp_ret_q <= bus_i.wdata[B_SLP_RET];
        deep_q    <= bus_i.wdata[B_DEEP];
        pend_ev_q <= bus_i.wdata[B_PEND_EV];
      end
      if (wr_dbg)
        halt_q <= bus_i.wdata[B_DBG_HLT];
    end
  end

  // Survives local reset: only power-on or a write to the debug register clears it
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dbg_en_q <= 1'b0;
    else if (wr_dbg)
      dbg_en_q <= bus_i.wdata[B_DBG_EN];
  end

  assign dbg_halt_o = halt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Exception number and clear-active

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      exc_num_q    <= 9'h000;
      clr_active_o <= 1'b0;
    end
    else
    begin
      clr_active_o <= clr_act;
      if (clr_act || loc_q)
        exc_num_q <= 9'h000;
      else if (exc_enter_i)
        exc_num_q <= exc_num_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up sources

  wire preempt  = async_i && (async_prio_i < act_prio_i);
  wire dbg_wake = dbg_evt_i && dbg_en_q;
  wire pm_gate  = pm_q && !fm_q && (base_q != 8'h00);
  // With the priority mask set, only exceptions above the threshold end the wait
  wire int_wake = (preempt && !(pm_gate && async_prio_i >= base_q)) || dbg_wake;
  // Parked return ignores interrupts under the priority mask, saving a wake
  wire exit_wake = (preempt && !(pm_q && !fm_q)) || dbg_wake;
  wire evt_wake = event_in_i || send_event_hint_i
               || (pend_new_i && pend_ev_q)
               || preempt || dbg_wake;
  wire run      = (st_q == SEC_RUN);
  wire evt_hit  = run && wait_for_event_hint_i && ev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event register

  // Set beats clear; value after reset is defined here as clear
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ev_q <= 1'b0;
    else if (loc_q)
      ev_q <= 1'b0;
    else if (evt_wake || exc_return_i)
      ev_q <= 1'b1;
    else if (run && wait_for_event_hint_i)
      ev_q <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      event_out_o <= 1'b0;
    else
      event_out_o <= send_event_hint_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine

  wire park = run && exc_return_i && ret_last_active_i && slp_ret_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SEC_RUN:
        if (wait_for_event_hint_i && !ev_q)
          st_d = SEC_EVT_SLP;
        else if (wait_for_interrupt_hint_i)
          st_d = SEC_INT_SLP;
        else if (park)
          st_d = SEC_EXIT_SLP;
      SEC_EVT_SLP:
        if (evt_wake || ev_q)
          st_d = SEC_RUN;
      SEC_INT_SLP:
        // Only wakes seen while parked here count
        if (int_wake)
          st_d = SEC_RUN;
      SEC_EXIT_SLP:
        if (exit_wake)
          st_d = SEC_RUN;
      default:
        st_d = SEC_RUN;
    endcase
  end

  wire leaving = !run && (st_d == SEC_RUN);

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q         <= SEC_RUN;
      sleeping_o   <= 1'b0;
      deep_sleep_o <= 1'b0;
      resume_o     <= 1'b0;
      ret_held_o   <= 1'b0;
      chain_o      <= 1'b0;
    end
    else
    begin
      st_q         <= loc_q ? SEC_RUN : st_d;
      sleeping_o   <= !loc_q && (st_d != SEC_RUN);
      deep_sleep_o <= !loc_q && (st_d != SEC_RUN) && deep_q;
      resume_o     <= !loc_q && (evt_hit || (leaving && st_q != SEC_EXIT_SLP));
      ret_held_o   <= !loc_q && park;
      chain_o      <= !loc_q && leaving && st_q == SEC_EXIT_SLP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Faults at priority -1 and -2

  wire hi_prio  = (flt_i.prio == PRIO_HF) || (flt_i.prio == PRIO_NMI);
  wire lk_insn  = hi_prio && (flt_i.supervisor_call || flt_i.usage_fault
                || flt_i.breakpoint_instruction);
  wire lk_ret   = flt_i.invalid_return_pc_fault && (flt_i.prio == PRIO_NMI);
  wire chain_hf = flt_i.invalid_return_pc_fault && (flt_i.prio == PRIO_HF);

  // Lock-up holds until a local or power-on reset
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_q         <= 1'b0;
      lprio_q        <= PRIO_NORM;
      laddr_q        <= RD_ZERO;
      hf_tailchain_o <= 1'b0;
    end
    else if (loc_q)
    begin
      lock_q         <= 1'b0;
      lprio_q        <= PRIO_NORM;
      hf_tailchain_o <= 1'b0;
    end
    else
    begin
      hf_tailchain_o <= chain_hf && !lock_q;
      if (!lock_q && lk_insn)
      begin
        lock_q  <= 1'b1;
        lprio_q <= flt_i.prio;
        laddr_q <= flt_i.pc;
      end
      else if (!lock_q && lk_ret)
      begin
        lock_q  <= 1'b1;
        lprio_q <= PRIO_NMI;
        laddr_q <= LOCK_ADDR_ONES;
      end
    end
  end

  assign lockup_o      = lock_q;
  assign lockup_prio_o = lprio_q;
  assign lockup_addr_o = laddr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  wire quiet = !lock_q && !loc_q;

  sequence s_park;
    run && exc_return_i && ret_last_active_i && slp_ret_q && !loc_q;
  endsequence

  sequence s_parked;
    ret_held_o && sleeping_o && !resume_o;
  endsequence

  svc_lock_a: assert property (quiet && hi_prio && flt_i.supervisor_call |=>
    lockup_o && lockup_addr_o == $past(flt_i.pc) && lockup_prio_o == $past(flt_i.prio))
    else $error("supervisor call at high priority did not lock");

  usage_lock_a: assert property (quiet && hi_prio && (flt_i.usage_fault
    || flt_i.breakpoint_instruction) |=> lockup_o && lockup_addr_o == $past(flt_i.pc))
    else $error("fault at high priority did not lock");

  invalid_return_pc_fault_chain_a: assert property (quiet && chain_hf && !lk_insn |=>
    hf_tailchain_o && !lockup_o)
    else $error("bad return from -1 did not tail-chain");

  sys_req_a: assert property (sys_wr && !req_q && !loc_q |=>
    sys_reset_req_o ##[1:30] local_rst_o)
    else $error("system reset request gave no local reset");

  vec_rst_a: assert property (vec_wr |=> local_rst_o)
    else $error("local reset bit did not reset core");

  clr_act_a: assert property (clr_act |=> clr_active_o && exc_num_q == 9'h000)
    else $error("clear-active left exception number set");

  dbg_keep_a: assert property (local_rst_o && !wr_dbg |=>
    dbg_en_q == $past(dbg_en_q) && !dbg_halt_o)
    else $error("local reset disturbed debug enable");

  ev_set_a: assert property ((evt_wake || exc_return_i) && !loc_q |=> ev_q)
    else $error("wake event not remembered");

  evt_hit_a: assert property (evt_hit && !loc_q |=> resume_o && !sleeping_o &&
    (!ev_q || $past(evt_wake || exc_return_i)))
    else $error("wait with event set did not return at once");

  evt_slp_a: assert property (run && wait_for_event_hint_i && !ev_q && !loc_q
    |=> sleeping_o)
    else $error("wait with event clear did not suspend");

  // A wake in the parked cycle may end the sleep at once
  park_a: assert property (s_park |=> s_parked ##1
    ($past(exit_wake || loc_q) || (sleeping_o && st_q == SEC_EXIT_SLP)))
    else $error("sleep on return not held");

  // Qualifier is registered with the state, so a later write shows a cycle late
  deep_a: assert property (deep_sleep_o == (sleeping_o && $past(deep_q)))
    else $error("deep-sleep shown while running");

  event_out_a: assert property (send_event_hint_i |=> event_out_o)
    else $error("send-event not signalled");

endmodule

/* sec_peer.sv */
// Purpose: Another processor of the system, seen from the core's event pins
// Assumes: Send commands from the bench are one-cycle pulses
// Notes:   Answer delay is a parameter so that slow peers can be tried
`timescale 1ns/100ps
module sec_peer
#(
  parameter int DLY = 4
)
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // Event traffic
  input  wire logic       send_i,
  input  wire logic       event_out_i,
  output logic            event_o,
  output logic [7:0]      seen_o
);
  logic [3:0] cnt_q;

  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cnt_q   <= 4'h0;
      event_o <= 1'b0;
      seen_o  <= 8'h00;
    end
    else
    begin
      // Never answers in the cycle of the command, so a slow peer is the norm
      cnt_q   <= send_i ? 4'(DLY) : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
      event_o <= (cnt_q == 4'h1);
      if (event_out_i)
        seen_o <= seen_o + 8'h01;
    end
endmodule

/* sec_pkg.sv */
// Purpose: Shared constants and carriers for the sleep, event and reset control block
// Assumes: 32-bit register port, byte offsets, one 200 MHz clock
// Notes:   Priority levels -1 and -2 are carried as small codes
package sec_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RST  = 8'h00;
  localparam logic [7:0] OFF_SCR  = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_LKAD = 8'h10;
  localparam logic [7:0] OFF_DBG  = 8'h14;

  // Reset control bits
  localparam int B_CLR_ACT = 0;
  localparam int B_LOC_RST = 1;
  localparam int B_SYS_REQ = 2;

  // Sleep configuration bits
  localparam int B_SLP_RET = 1;
  localparam int B_DEEP    = 2;
  localparam int B_PEND_EV = 4;

  // Mask register fields
  localparam int B_PRI_MSK = 0;
  localparam int B_FLT_MSK = 1;
  localparam int B_BASE_LO = 8;

  // Status register fields
  localparam int B_ST_LO   = 0;
  localparam int B_LOCK    = 4;
  localparam int B_LPRI_LO = 5;
  localparam int B_REQ_PND = 7;
  localparam int B_EXC_LO  = 8;

  // Debug control bits
  localparam int B_DBG_EN  = 0;
  localparam int B_DBG_HLT = 1;

  // Execution priority codes
  localparam logic [1:0] PRIO_NORM = 2'h0;
  localparam logic [1:0] PRIO_HF   = 2'h1;
  localparam logic [1:0] PRIO_NMI  = 2'h2;

  localparam logic [31:0] LOCK_ADDR_ONES = 32'hffffffff;
  localparam logic [31:0] RD_ZERO        = 32'h00000000;

  // Delay from a system reset request to the local core reset
  localparam int CLK_PS       = 5000;
  localparam int SRST_DLY_NS  = 100;
  localparam int SRST_DLY_CYC = (SRST_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [7:0] SRST_CNT_INIT = 8'(SRST_DLY_CYC);

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } sec_bus_t;

  // One fault report from the execution pipeline
  typedef struct packed {
    logic        supervisor_call;
    logic        usage_fault;
    logic        invalid_return_pc_fault;
    logic        breakpoint_instruction;
    logic [1:0]  prio;
    logic [31:0] pc;
  } sec_flt_t;

  typedef enum logic [1:0] {
    SEC_RUN,
    SEC_EVT_SLP,
    SEC_INT_SLP,
    SEC_EXIT_SLP
  } sec_state_t;

endpackage

/* test_sleep_event_reset_control.sv */
// Purpose: Self-checking bench for the sleep, event and reset control block
// Assumes: One 200 MHz clock, asynchronous active-low reset
// Notes:   Read data are compared from a queue of expected words
`timescale 1ns/100ps
module test_sleep_event_reset_control;
  import sec_pkg::*;

  logic        mclk_i  = 1'b0;
  logic        rstn_i  = 1'b0;
  sec_bus_t    bus     = '0;
  sec_flt_t    flt     = '0;
  sec_flt_t    f;
  logic [7:0]  pl      = 8'h00; // wfe wfi sev ret enter pend dbg peer
  logic        last    = 1'b0;
  logic        async   = 1'b0;
  logic [7:0]  aprio   = 8'h00;
  logic [7:0]  act     = 8'h10;
  logic [8:0]  exc_num = 9'h000;
  logic [31:0] rdata_o;
  logic [31:0] laddr;
  logic        sleeping, deep, resume, held, chain, ev_out, ev_in;
  logic        sreq, lrst, clr, halt, lock, hftc;
  logic [1:0]  lprio;
  logic [7:0]  seen;
  logic        rd_pend = 1'b0;
  logic [31:0] expq[$];
  int          num_errors = 0;
  int          n_tests = 0;
  int          seed;
  int          k;

  always #2.5 mclk_i = ~mclk_i;

  sec_ctrl u_sec_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata_o),
    .wait_for_event_hint_i(pl[0]), .wait_for_interrupt_hint_i(pl[1]),
    .send_event_hint_i(pl[2]), .exc_return_i(pl[3]), .ret_last_active_i(last),
    .exc_enter_i(pl[4]), .exc_num_i(exc_num), .pend_new_i(pl[5]), .async_i(async),
    .async_prio_i(aprio), .act_prio_i(act), .dbg_evt_i(pl[6]), .event_in_i(ev_in),
    .flt_i(flt), .sleeping_o(sleeping), .deep_sleep_o(deep), .resume_o(resume),
    .ret_held_o(held), .chain_o(chain), .event_out_o(ev_out), .sys_reset_req_o(sreq),
    .local_rst_o(lrst), .clr_active_o(clr), .dbg_halt_o(halt), .lockup_o(lock),
    .lockup_prio_o(lprio), .lockup_addr_o(laddr), .hf_tailchain_o(hftc));

  sec_peer #(.DLY(6)) u_sec_peer (.mclk_i(mclk_i), .rstn_i(rstn_i), .send_i(pl[7]),
    .event_out_i(ev_out), .event_o(ev_in), .seen_o(seen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_i) rd_pend <= bus.re;
  always @(negedge mclk_i)
    if (rd_pend)
      chk(rdata_o, expq.pop_front());

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.we    <= 1'b1;
    @(posedge mclk_i);
    bus.we    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.re   <= 1'b1;
    @(posedge mclk_i);
    bus.re   <= 1'b0;
    expq.push_back(e);
  endtask

  // Waits one edge first so no strobe is raised and lowered in one step
  task automatic pulse(input int i);
    @(posedge mclk_i);
    pl[i] <= 1'b1;
    @(posedge mclk_i);
    pl[i] <= 1'b0;
    #1;
  endtask

  task automatic fault(input sec_flt_t v);
    @(posedge mclk_i);
    flt <= v;
    @(posedge mclk_i);
    flt <= '0;
    #1;
  endtask

  function automatic logic hit(input int s);
    return s ? chain : resume;
  endfunction

  task automatic wake(input int s);
    k = 0;
    // Let outputs settle when called in the time step of an edge
    #1;
    while (hit(s) !== 1'b1 && k < 20)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    chk(hit(s), 1);
    chk(sleeping, 0);
  endtask

  task automatic core_reset();
    wr(OFF_DBG, 32'h3);
    #1;
    chk(halt, 1);
    wr(OFF_RST, 32'h2);
    #1;
    chk(lrst, 1);
    @(posedge mclk_i);
    #1;
    chk(lock, 0);
    chk(halt, 0);
    rd(OFF_DBG, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 58356;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1;
    chk({sleeping, lock, sreq, lrst}, 0);
    rd(OFF_SCR, 0);
    rd(OFF_STAT, 0);
    rd(OFF_RST, 0);
    rd(8'h3c, 0);
    f = '0;
    f.pc = $random(seed);
    wr(OFF_SCR, f.pc);
    rd(OFF_SCR, f.pc & 32'h16);
    f.pc = $random(seed);
    wr(OFF_MASK, f.pc);
    rd(OFF_MASK, f.pc & 32'hff03);
    wr(OFF_MASK, 0);
    wr(OFF_SCR, 32'h4);
    pulse(0);
    chk({sleeping, deep}, 2'b11);
    rd(OFF_STAT, 32'h1);
    pulse(5);
    chk(sleeping, 1);
    pulse(7);
    wake(0);
    chk(deep, 0);
    pulse(0);
    chk({resume, sleeping}, 2'b10);
    pulse(0);
    chk(sleeping, 1);
    wr(OFF_SCR, 32'h10);
    pulse(5);
    wake(0);
    pulse(0);
    chk(resume, 1);
    pulse(0);
    pulse(2);
    chk(ev_out, 1);
    wake(0);
    pulse(0);
    pulse(0);
    pulse(6);
    chk(sleeping, 1);
    wr(OFF_DBG, 32'h1);
    pulse(6);
    wake(0);
    pulse(0);
    pulse(0);
    @(posedge mclk_i);
    async <= 1'b1;
    aprio <= 8'h10;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(sleeping, 1);
    @(posedge mclk_i);
    act   <= 8'h18;
    wake(0);
    @(posedge mclk_i);
    async <= 1'b0;
    // Peer event lands before the interrupt wait and must not end it
    pulse(7);
    repeat (10) @(posedge mclk_i);
    wr(OFF_MASK, 32'h0401);
    pulse(1);
    chk(sleeping, 1);
    @(posedge mclk_i);
    async <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(sleeping, 1);
    @(posedge mclk_i);
    aprio <= 8'h02;
    wake(0);
    @(posedge mclk_i);
    async <= 1'b0;
    wr(OFF_MASK, 0);
    pulse(0);
    chk(resume, 1);
    pulse(3);
    pulse(0);
    chk(resume, 1);
    wr(OFF_SCR, 32'h2);
    @(posedge mclk_i);
    last <= 1'b1;
    pulse(3);
    chk({held, sleeping}, 2'b11);
    wr(OFF_MASK, 32'h1);
    @(posedge mclk_i);
    async <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    chk(sleeping, 1);
    wr(OFF_MASK, 0);
    wake(1);
    @(posedge mclk_i);
    async <= 1'b0;
    last  <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      f = '0;
      f.pc = $random(seed);
      f.prio = 2'(i / 3);
      {f.supervisor_call, f.usage_fault, f.breakpoint_instruction} = 3'b100 >> (i % 3);
      fault(f);
      chk(lock, f.prio != 2'h0);
      if (f.prio != 2'h0)
      begin
        chk(lprio, f.prio);
        chk(laddr, f.pc);
        core_reset();
      end
    end
    f = '0;
    f.invalid_return_pc_fault = 1'b1;
    f.prio = PRIO_HF;
    fault(f);
    chk({hftc, lock}, 2'b10);
    f.prio = PRIO_NMI;
    fault(f);
    chk({lock, lprio}, {1'b1, PRIO_NMI});
    chk(laddr, LOCK_ADDR_ONES);
    core_reset();
    f.pc = $random(seed);
    @(posedge mclk_i);
    exc_num <= f.pc[8:0] | 9'h001;
    pulse(4);
    rd(OFF_STAT, {15'h0, exc_num, 8'h00});
    wr(OFF_RST, 32'h1);
    #1;
    chk(clr, 1);
    rd(OFF_STAT, 0);
    wr(OFF_RST, 32'h4);
    #1;
    chk(sreq, 1);
    k = 0;
    // Spin until the delayed reset lands, as software would after a barrier
    while (lrst !== 1'b1 && k < 100)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    chk(k, SRST_DLY_CYC + 1);
    chk({lrst, sreq}, 2'b10);
    rd(OFF_DBG, 32'h1);
    chk(seen, 1);
    repeat (3) @(posedge mclk_i);
    stop_test();
  end

  // The whole sequence needs about 240 cycles
  initial
  begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule
